//--- pkg/wrc_pkg.sv
// Constants and types for the write-check input mapper of a burst-chop-4 write frame
package wrc_pkg;

  // ==========================================================
  // Frame shape
  localparam int FRAME_UI   = 10;  // Frame length with write checking on
  localparam int DATA_UI    = 4;   // Beats carrying data in a chopped burst
  localparam int CHECK_UI   = 8;   // Beat carrying the check bits
  localparam int LANES      = 8;   // Data lanes per byte half
  localparam int TREE_IN_W  = 72;  // Inputs of one check tree
  localparam int MASK_LO_POS = 64; // Tree slot of the mask lane, lower half-burst
  localparam int MASK_HI_POS = 68; // Tree slot of the mask lane, upper half-burst
  localparam int CNT_W      = 4;

  // ==========================================================
  // Sampled pin vector layout
  localparam int PIN_W      = 20;
  localparam int PIN_DQ     = 0;   // 16 data lanes
  localparam int PIN_MASK_L = 16;
  localparam int PIN_MASK_U = 17;
  localparam int PIN_FRAME  = 18;
  localparam int PIN_A2     = 19;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RXCRC  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CALC   = 8'h10;

  // Control bits
  localparam int CTRL_W      = 4;
  localparam int CTRL_CRC_EN = 0;
  localparam int CTRL_DM_EN  = 1;
  localparam int CTRL_DBI_EN = 2;
  localparam int CTRL_X16    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Event bits of status and mask
  localparam int EV_W       = 4;
  localparam int EV_ERR_LO  = 0;
  localparam int EV_ERR_HI  = 1;
  localparam int EV_SHORT   = 2;
  localparam int EV_DONE    = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;

  typedef enum logic [3:0] {
    WRC_IDLE    = 4'b0001,
    WRC_COLLECT = 4'b0010,
    WRC_CHECK   = 4'b0100,
    WRC_WAIT    = 4'b1000
  } wrc_state_t;

endpackage

//--- hw/wrc_sampler.sv
// Pin synchroniser and strobe edge finder feeding one unit interval per strobe edge
`timescale 1ns/1ns
module wrc_sampler
  import wrc_pkg::*;
#(
  parameter int W = PIN_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         strobe_pin,
  input  wire logic [W-1:0] data_pin,
  output logic              ui_pulse,
  output logic [W-1:0]      ui_data,
  output logic [W-1:0]      data_lvl
);

  // ==========================================================
  // Two-stage synchronisers
  logic [W-1:0] data_m;
  logic [W-1:0] data_s;
  logic         strb_m;
  logic         strb_s;
  logic         strb_d;
  logic [W-1:0] next_ui_data;
  logic         next_ui_pulse;

  // Both strobe edges carry data, so any change of level marks a UI
  always_comb begin
    next_ui_pulse = strb_s ^ strb_d;
    next_ui_data  = next_ui_pulse ? data_s : ui_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_m   <= '0;
      data_s   <= '0;
      strb_m   <= 1'b0;
      strb_s   <= 1'b0;
      strb_d   <= 1'b0;
      ui_pulse <= 1'b0;
      ui_data  <= '0;
    end else begin
      data_m   <= data_pin;
      data_s   <= data_m;
      strb_m   <= strobe_pin;
      strb_s   <= strb_m;
      strb_d   <= strb_s;
      ui_pulse <= next_ui_pulse;
      ui_data  <= next_ui_data;
    end
  end

  assign data_lvl = data_s;

endmodule // wrc_sampler

//--- hw/wrc_tree.sv
// One check tree: maps a chopped half-burst onto 72 inputs and folds them to 8 bits
`timescale 1ns/1ns
module wrc_tree
  import wrc_pkg::*;
#(
  parameter logic [7:0] POLY = 8'h07,
  parameter logic [7:0] INIT = 8'h00
) (
  input  wire logic [LANES*DATA_UI-1:0] lanes,
  input  wire logic [DATA_UI-1:0]       mlane,
  input  wire logic                     a2,
  input  wire logic                     mask_on,
  output logic [7:0]                    crc
);

  // ==========================================================
  // Input mapping; unused slots are ones
  function automatic logic [TREE_IN_W-1:0] map_inputs(
    input logic [LANES*DATA_UI-1:0] ln,
    input logic [DATA_UI-1:0]       ml,
    input logic                     hi,
    input logic                     mon
  );
    logic [TREE_IN_W-1:0] d;
    d = '1;
    // Data of either half-burst lands in the lower nibble slots
    for (int n = 0; n < LANES; n++) begin
      for (int k = 0; k < DATA_UI; k++) begin
        d[8*n+k] = ln[DATA_UI*n+k];
      end
    end
    for (int k = 0; k < DATA_UI; k++) begin
      if (mon && !hi) begin
        d[MASK_LO_POS+k] = ml[k];
      end
      if (mon && hi) begin
        d[MASK_HI_POS+k] = ml[k];
      end
    end
    return d;
  endfunction

  // ==========================================================
  // Serial fold, bit 0 first
  function automatic logic [7:0] fold(input logic [TREE_IN_W-1:0] d);
    logic [7:0] c;
    logic       fb;
    c = INIT;
    for (int i = 0; i < TREE_IN_W; i++) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ POLY;
      end
    end
    return c;
  endfunction

  always_comb begin
    crc = fold(map_inputs(lanes, mlane, a2, mask_on));
  end

endmodule // wrc_tree

//--- hw/wrc_checker.sv
// Write-frame checker: collects ten unit intervals, maps them and compares check bits
`timescale 1ns/1ns
module wrc_checker
  import wrc_pkg::*;
#(
  parameter logic [7:0] POLY = 8'h07,
  parameter logic [7:0] INIT = 8'h00
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  input  wire logic              DQS,
  input  wire logic [15:0]       DQ,
  input  wire logic              MASK_L,
  input  wire logic              MASK_U,
  input  wire logic              FRAME,
  input  wire logic              A2,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic [31:0]            RD_DATA,
  output logic                   CRC_ERR,
  output logic                   IRQ
);

  // ==========================================================
  // Pin sampling
  logic              ui_pulse;
  logic [PIN_W-1:0]  ui_data;
  logic [PIN_W-1:0]  pin_lvl;
  logic              frame_lvl;

  wrc_sampler #(
    .W (PIN_W)
  ) u_sampler (
    .clk        (CLK_SYS),
    .rst        (RESET),
    .strobe_pin (DQS),
    .data_pin   ({A2, FRAME, MASK_U, MASK_L, DQ}),
    .ui_pulse   (ui_pulse),
    .ui_data    (ui_data),
    .data_lvl   (pin_lvl)
  );

  assign frame_lvl = pin_lvl[PIN_FRAME];

  // ==========================================================
  // Registers
  logic [CTRL_W-1:0] ctrl;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   mask;
  logic [15:0]       rx_crc;
  logic [15:0]       calc_crc;
  logic [CTRL_W-1:0] next_ctrl;
  logic [EV_W-1:0]   next_status;
  logic [EV_W-1:0]   next_mask;
  logic [31:0]       next_rd_data;
  logic [EV_W-1:0]   events;
  logic              mask_on;
  logic              x16;

  assign mask_on = ctrl[CTRL_DM_EN] | ctrl[CTRL_DBI_EN];
  assign x16     = ctrl[CTRL_X16];

  // ==========================================================
  // Frame collection
  wrc_state_t        state;
  wrc_state_t        next_state;
  logic [CNT_W-1:0]  ui_cnt;
  logic [CNT_W-1:0]  next_ui_cnt;
  logic [PIN_W-1:0]  beat [FRAME_UI];
  logic [PIN_W-1:0]  next_beat [FRAME_UI];
  logic              a2_lat;
  logic              next_a2_lat;
  logic [15:0]       next_rx_crc;
  logic [15:0]       next_calc_crc;
  logic              next_crc_err;
  logic [7:0]        crc_lo;
  logic [7:0]        crc_hi;

  localparam logic [CNT_W-1:0] LAST_UI = CNT_W'(FRAME_UI - 1);

  always_comb begin
    next_state    = state;
    next_ui_cnt   = ui_cnt;
    next_a2_lat   = a2_lat;
    next_beat     = beat;
    next_rx_crc   = rx_crc;
    next_calc_crc = calc_crc;
    next_crc_err  = 1'b0;
    events        = '0;
    unique case (state)
      WRC_IDLE: begin
        // Frames are only tracked while checking is on
        if (ui_pulse && frame_lvl && ctrl[CTRL_CRC_EN]) begin
          next_beat[0] = ui_data;
          next_a2_lat  = ui_data[PIN_A2];
          next_ui_cnt  = CNT_W'(1);
          next_state   = WRC_COLLECT;
        end
      end
      WRC_COLLECT: begin
        if (ui_pulse) begin
          next_beat[ui_cnt] = ui_data;
          next_ui_cnt       = ui_cnt + CNT_W'(1);
          if (ui_cnt == LAST_UI) begin
            next_state = WRC_CHECK;
          end
        end else if (!frame_lvl) begin
          events[EV_SHORT] = 1'b1;
          next_state       = WRC_IDLE;
        end
      end
      WRC_CHECK: begin
        next_rx_crc   = beat[CHECK_UI][15:0];
        next_calc_crc = {crc_hi, crc_lo};
        events[EV_DONE]   = 1'b1;
        events[EV_ERR_LO] = crc_lo != beat[CHECK_UI][7:0];
        events[EV_ERR_HI] = x16 && (crc_hi != beat[CHECK_UI][15:8]);
        next_crc_err      = events[EV_ERR_LO] | events[EV_ERR_HI];
        next_state        = WRC_WAIT;
      end
      WRC_WAIT: begin
        // A frame held open longer than ten UIs is closed here, not rechecked
        if (!frame_lvl) begin
          next_state = WRC_IDLE;
        end
      end
    endcase
  end

  // Beats clear on reset so a stale frame never reaches the trees
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state    <= WRC_IDLE;
      ui_cnt   <= '0;
      a2_lat   <= 1'b0;
      for (int i = 0; i < FRAME_UI; i++) begin
        beat[i] <= '0;
      end
      rx_crc   <= '0;
      calc_crc <= '0;
    end else begin
      state    <= next_state;
      ui_cnt   <= next_ui_cnt;
      a2_lat   <= next_a2_lat;
      beat     <= next_beat;
      rx_crc   <= next_rx_crc;
      calc_crc <= next_calc_crc;
    end
  end

  // ==========================================================
  // Two trees, one per byte half
  logic [LANES*DATA_UI-1:0] lanes_lo;
  logic [LANES*DATA_UI-1:0] lanes_hi;
  logic [DATA_UI-1:0]       mlane_lo;
  logic [DATA_UI-1:0]       mlane_hi;

  always_comb begin
    for (int k = 0; k < DATA_UI; k++) begin
      for (int n = 0; n < LANES; n++) begin
        lanes_lo[DATA_UI*n+k] = beat[k][PIN_DQ+n];
        lanes_hi[DATA_UI*n+k] = beat[k][PIN_DQ+LANES+n];
      end
      mlane_lo[k] = beat[k][PIN_MASK_L];
      mlane_hi[k] = beat[k][PIN_MASK_U];
    end
  end

  wrc_tree #(
    .POLY (POLY),
    .INIT (INIT)
  ) u_tree_lo (
    .lanes   (lanes_lo),
    .mlane   (mlane_lo),
    .a2      (a2_lat),
    .mask_on (mask_on),
    .crc     (crc_lo)
  );

  // Independent copy for the upper byte half
  wrc_tree #(
    .POLY (POLY),
    .INIT (INIT)
  ) u_tree_hi (
    .lanes   (lanes_hi),
    .mlane   (mlane_hi),
    .a2      (a2_lat),
    .mask_on (mask_on),
    .crc     (crc_hi)
  );

  // ==========================================================
  // Register access
  // One decode shared by every writable register
  function automatic logic wr_hit(
    input logic              en,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return en && (a == ofs);
  endfunction

  always_comb begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_status  = status;
    next_rd_data = '0;
    if (wr_hit(WR_EN, ADDR, OFS_CTRL)) begin
      next_ctrl = WR_DATA[CTRL_W-1:0];
    end
    if (wr_hit(WR_EN, ADDR, OFS_MASK)) begin
      next_mask = WR_DATA[EV_W-1:0];
    end
    if (wr_hit(WR_EN, ADDR, OFS_STATUS)) begin
      next_status = status & ~WR_DATA[EV_W-1:0];
    end
    // Set after clear so a same-cycle event is never lost
    next_status = next_status | events;
    if (RD_EN) begin
      unique case (ADDR)
        OFS_CTRL:   next_rd_data = {{(32-CTRL_W){1'b0}}, ctrl};
        OFS_STATUS: next_rd_data = {{(32-EV_W){1'b0}}, status};
        OFS_MASK:   next_rd_data = {{(32-EV_W){1'b0}}, mask};
        OFS_RXCRC:  next_rd_data = {16'h0000, rx_crc};
        OFS_CALC:   next_rd_data = {16'h0000, calc_crc};
        default:    next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl   <= CTRL_RST;
      status <= EV_RST;
      mask   <= EV_RST;
    end else begin
      ctrl   <= next_ctrl;
      status <= next_status;
      mask   <= next_mask;
    end
  end

  // ==========================================================
  // Outputs
  logic next_irq;

  // Follows the status being written, so the line rises with the event
  always_comb begin
    next_irq = |(next_status & next_mask);
  end

  // Pulse and read data last one cycle since their next values default low
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      CRC_ERR <= 1'b0;
      IRQ     <= 1'b0;
      RD_DATA <= '0;
    end else begin
      CRC_ERR <= next_crc_err;
      IRQ     <= next_irq;
      RD_DATA <= next_rd_data;
    end
  end

endmodule // wrc_checker

//--- verification/wrc_checker_chk.sv
// Port-level assertions for the write-frame checker
`timescale 1ns/1ns
module wrc_checker_chk
  import wrc_pkg::*;
(
  input wire logic              CLK_SYS,
  input wire logic              RESET,
  input wire logic              DQS,
  input wire logic [15:0]       DQ,
  input wire logic              MASK_L,
  input wire logic              MASK_U,
  input wire logic              FRAME,
  input wire logic              A2,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0]       WR_DATA,
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [31:0]       RD_DATA,
  input wire logic              CRC_ERR,
  input wire logic              IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ====
  // Shadows of written control and mask, strobe edges per frame, idle time
  logic            crc_on;
  logic            dqs_q;
  logic            frame_q;
  logic [EV_W-1:0] msk;
  logic [3:0]      ui_cnt;
  logic [3:0]      idle_cnt;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      crc_on   <= 1'b0;
      msk      <= '0;
      dqs_q    <= 1'b0;
      frame_q  <= 1'b0;
      ui_cnt   <= '0;
      idle_cnt <= '0;
    end else begin
      dqs_q   <= DQS;
      frame_q <= FRAME;
      if (WR_EN && ADDR == OFS_CTRL) crc_on <= WR_DATA[CTRL_CRC_EN];
      if (WR_EN && ADDR == OFS_MASK) msk <= WR_DATA[EV_W-1:0];
      if (FRAME && !frame_q) ui_cnt <= '0;
      else if (FRAME && DQS != dqs_q && ui_cnt != 4'hf) ui_cnt <= ui_cnt + 4'h1;
      idle_cnt <= FRAME ? 4'h0 : (idle_cnt == 4'hf ? idle_cnt : idle_cnt + 4'h1);
    end
  end
  sequence s_err_unmasked;
    CRC_ERR && msk[EV_ERR_LO] && msk[EV_ERR_HI];
  endsequence
  // ====
  // Assertions
  a_err_one_cycle: assert property (CRC_ERR |=> !CRC_ERR)
    else $error("mismatch pulse longer than one cycle");
  a_err_after_ten: assert property (CRC_ERR |-> ui_cnt >= 4'ha)
    else $error("mismatch flagged before ten unit intervals");
  a_err_when_on: assert property (CRC_ERR |-> crc_on)
    else $error("mismatch flagged with checking off");
  a_err_near_frame: assert property (CRC_ERR |-> idle_cnt <= 4'h8)
    else $error("mismatch flagged long after the frame");
  a_err_raises_irq: assert property (s_err_unmasked |-> ##[1:2] IRQ)
    else $error("unmasked mismatch gave no interrupt");
  a_irq_needs_mask: assert property (IRQ |-> (|msk) || $past(|msk))
    else $error("interrupt with every event masked");
  a_rd_idle_zero: assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
    else $error("read data outside the answer cycle");
  a_rst_quiet: assert property ($fell(RESET) |-> !IRQ && !CRC_ERR)
    else $error("outputs active after reset");
endmodule // wrc_checker_chk

bind wrc_checker wrc_checker_chk i_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .DQS(DQS), .DQ(DQ), .MASK_L(MASK_L), .MASK_U(MASK_U),
  .FRAME(FRAME), .A2(A2), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RD_DATA(RD_DATA), .CRC_ERR(CRC_ERR), .IRQ(IRQ)
);

//--- verification/wrc_ctl_model.sv
// Behavioural controller driving chopped write frames onto the link pins
`timescale 1ns/1ns
module wrc_ctl_model (
  output logic        DQS,
  output logic [15:0] DQ,
  output logic        MASK_L,
  output logic        MASK_U,
  output logic        FRAME,
  output logic        A2
);
  initial begin
    DQS    = 1'b0;
    DQ     = 16'h0;
    MASK_L = 1'b1;
    MASK_U = 1'b1;
    FRAME  = 1'b0;
    A2     = 1'b0;
  end
  // ====
  // Frame of n unit intervals, 80 ns each; strobe stands still between frames
  task automatic send(input logic [63:0] d, input logic [7:0] m, input logic [15:0] c,
                      input logic a2, input int n);
    // Leave the system clock edge the caller returned on
    #10;
    FRAME = 1'b1;
    A2    = a2;
    for (int k = 0; k < n; k++) begin
      DQ = k < 4 ? d[16 * k +: 16] : (k == 8 ? c : 16'hffff);
      {MASK_U, MASK_L} = k < 4 ? m[2 * k +: 2] : 2'b11;
      #40 DQS = ~DQS;
      #40;
    end
    FRAME = 1'b0;
    // Released lines flip so a stale value never looks valid
    DQ = ~DQ;
    {MASK_U, MASK_L} = ~{MASK_U, MASK_L};
    #100;
  endtask
endmodule // wrc_ctl_model

//--- verification/wrc_checker_bench.sv
// Self-checking bench: registers, frame mapping, mismatch flags and interrupt
`timescale 1ns/1ns
module wrc_checker_bench
  import wrc_pkg::*;
;
  localparam logic [7:0] POLY = 8'h07;
  logic              CLK_SYS, RESET, WR_EN, RD_EN, DQS, MASK_L, MASK_U, FRAME, A2;
  logic              CRC_ERR, IRQ;
  logic [ADDR_W-1:0] ADDR;
  logic [31:0]       WR_DATA, RD_DATA;
  logic [15:0]       DQ;
  int                n_errors, cmp_count, n_pulse;
  wrc_ctl_model i_ctl (.DQS(DQS), .DQ(DQ), .MASK_L(MASK_L), .MASK_U(MASK_U), .FRAME(FRAME),
                       .A2(A2));
  wrc_checker #(.POLY(POLY), .INIT(8'h00)) i_dut (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .DQS(DQS), .DQ(DQ), .MASK_L(MASK_L), .MASK_U(MASK_U),
    .FRAME(FRAME), .A2(A2), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
    .RD_DATA(RD_DATA), .CRC_ERR(CRC_ERR), .IRQ(IRQ));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (CRC_ERR === 1'b1) n_pulse++;
  // ====
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    WR_EN <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK_SYS);
    WR_EN <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD_EN <= 1'b0;
    @(negedge CLK_SYS) d = RD_DATA;
  endtask
  // Reference tree: half h, unused slots ones, bit 0 first
  function automatic logic [7:0] fold(input logic [63:0] d, input logic h,
                                      input logic [7:0] m, input logic a2, input logic mon);
    logic [71:0] t;
    logic [7:0]  c;
    logic        fb;
    t = '1;
    c = 8'h00;
    for (int i = 0; i < 32; i++) begin
      t[8 * (i % 8) + i / 8] = d[16 * (i / 8) + 8 * h + i % 8];
    end
    for (int k = 0; k < 4; k++) if (mon) t[(a2 ? 68 : 64) + k] = m[2 * k + h];
    for (int i = 0; i < 72; i++) begin
      fb = c[7] ^ t[i];
      c = {c[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
    end
    return c;
  endfunction
  task automatic frame(input int i, input logic [3:0] ctl, input logic [15:0] bad, input int n);
    logic [63:0] d;
    logic [7:0]  m, lo, hi;
    logic [31:0] v;
    logic [3:0]  ev;
    int          p;
    d = 64'hfedc_ba98_7654_3210 + 64'h1111_1111_1111_1111 * i;
    m = 8'ha5 ^ i[7:0];
    lo = fold(d, 1'b0, m, i[0], ctl[CTRL_DM_EN] | ctl[CTRL_DBI_EN]);
    hi = fold(d, 1'b1, m, i[0], ctl[CTRL_DM_EN] | ctl[CTRL_DBI_EN]);
    ev = {1'b1, 1'b0, ctl[CTRL_X16] & (|bad[15:8]), |bad[7:0]};
    if (n != 10) ev = 4'h4;
    if (!ctl[CTRL_CRC_EN]) ev = 4'h0;
    wr(OFS_CTRL, {28'h0, ctl});
    p = n_pulse;
    i_ctl.send(d, m, {hi, lo} ^ bad, i[0], n);
    rd(OFS_STATUS, v);
    check("status", v, {28'h0, ev});
    check("pulses", n_pulse - p, ev[0] | ev[1]);
    if (ev[3]) begin
      rd(OFS_CALC, v);
      v = v & (ctl[CTRL_X16] ? 32'hffff : 32'hff);
      check("calc", v, ctl[CTRL_X16] ? {hi, lo} : lo);
      rd(OFS_RXCRC, v);
      check("rxcrc", v, {16'h0, {hi, lo} ^ bad});
    end
  endtask
  // ====
  // Scenarios
  task automatic t_regs();
    logic [31:0] v;
    rd(OFS_CTRL, v);
    check("ctrl", v, {28'h0, CTRL_RST});
    rd(OFS_STATUS, v);
    check("status", v, {28'h0, EV_RST});
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, v);
    check("unmapped", v, 32'h0);
    wr(OFS_MASK, 32'hffff_fff3);
    rd(OFS_MASK, v);
    check("mask", v, 32'h3);
    $display("t_regs done");
  endtask
  // A2 both ways, x8 and x16, lane off, mask, inversion; wrong check bits in some
  task automatic t_map();
    for (int i = 0; i < 12; i++) begin
      frame(i, {i[1], i[3:2] == 2'h2, i[3:2] == 2'h1, 1'b1},
            i == 5 ? 16'h0100 : i == 6 ? 16'h0001 : i == 7 ? 16'h8000 : 16'h0, 10);
      wr(OFS_STATUS, 32'hf);
    end
    $display("t_map done");
  endtask
  task automatic t_refuse();
    frame(2, 4'h0, 16'h0001, 10);
    frame(1, 4'h1, 16'h0, 7);
    wr(OFS_STATUS, 32'hf);
    $display("t_refuse done");
  endtask
  task automatic t_irq();
    logic [31:0] v;
    wr(OFS_MASK, 32'h1);
    frame(3, 4'h1, 16'h0001, 10);
    check("irq", IRQ, 32'h1);
    wr(OFS_MASK, 32'h4);
    repeat (2) @(negedge CLK_SYS);
    check("irq", IRQ, 32'h0);
    wr(OFS_MASK, 32'h8);
    repeat (2) @(negedge CLK_SYS);
    check("irq", IRQ, 32'h1);
    wr(OFS_STATUS, 32'h8);
    repeat (2) @(negedge CLK_SYS);
    check("irq", IRQ, 32'h0);
    rd(OFS_STATUS, v);
    check("status", v, 32'h1);
    $display("t_irq done");
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    RESET = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = '0;
    WR_DATA = '0;
    repeat (5) @(posedge CLK_SYS);
    RESET <= 1'b0;
    t_regs();
    t_map();
    t_refuse();
    t_irq();
    conclude();
  end
  // About 15 frames of 1 us each; more than ten times that is a hang
  initial begin
    #200_000;
    n_errors++;
    conclude();
  end
endmodule // wrc_checker_bench
